// [scfg_pkg.sv]
package scfg_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] CORE_COMMAND_ADDR   = 10'h100;
  localparam logic [ADDR_W-1:0] LOOP_SELECT_ADDR    = 10'h101;
  localparam logic [ADDR_W-1:0] CP_CURRENT_ADDR     = 10'h102;
  localparam logic [ADDR_W-1:0] LOOP_FILTER_ADDR    = 10'h103;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CMD_CAL_BIT    = 3;
  localparam int CMD_SYNC_BIT   = 2;
  localparam int CMD_PDN_BIT    = 1;
  localparam int CMD_RST_BIT    = 0;
  localparam int SEL_DBL_BIT    = 3;
  localparam int SEL_MODE_HI    = 2;
  localparam int SEL_MODE_LO    = 1;
  localparam int SEL_SDMPD_BIT  = 0;
  localparam int LF_P2R_HI      = 7;
  localparam int LF_P2R_LO      = 6;
  localparam int LF_ZR_HI       = 5;
  localparam int LF_ZR_LO       = 3;
  localparam int LF_P1C_HI      = 2;
  localparam int LF_P1C_LO      = 0;
  localparam int CTRL_USED_BITS = 4;

  // ****************************************************************
  // Reset values and pump current scale
  // ****************************************************************
  localparam logic [3:0] CORE_COMMAND_RST  = 4'h0;
  localparam logic [1:0] LOOP_MODE_RST     = 2'h0;
  localparam logic       SDM_PDN_RST       = 1'h1;
  localparam logic       DOUBLER_RST       = 1'h0;
  localparam logic [7:0] CP_CURRENT_RST    = 8'h8d;
  localparam logic [1:0] POLE2_RES_RST     = 2'h3;
  localparam logic [2:0] ZERO_RES_RST      = 3'h5;
  localparam logic [2:0] POLE1_CAP_RST     = 3'h0;
  localparam int         CP_UA_PER_LSB     = 4;

  // ****************************************************************
  // Loop mode decode
  // ****************************************************************
  typedef enum logic [1:0] {
    LOOP_SINGLE   = 2'h0,
    LOOP_CASCADED = 2'h1,
    LOOP_FIXDELAY = 2'h2,
    LOOP_RESERVED = 2'h3
  } scfg_loop_mode_type;

endpackage

// [scfg_synth_core_config_regs.sv]
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module scfg_synth_core_config_regs (
  input  wire logic                         clock,
  input  wire logic                         resetn,
  input  wire logic [scfg_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [scfg_pkg::DATA_W-1:0]  regWrData,
  input  wire logic                         regWrite,
  input  wire logic                         regRead,
  output logic      [scfg_pkg::DATA_W-1:0]  regRdData,
  output logic                              vcoCalStart,
  output logic                              dividerSyncHold,
  output logic                              corePowerDown,
  output logic                              coreReset,
  output logic                              doublerSelect,
  output logic                              loopSingle,
  output logic                              loopCascaded,
  output logic                              loopFixedDelay,
  output logic                              loopReserved,
  output logic                              sdmPowerDown,
  output logic      [scfg_pkg::DATA_W-1:0]  chargePumpCode,
  output logic      [9:0]                   chargePumpMicroAmps,
  output logic      [1:0]                   pole2ResistorCode,
  output logic      [2:0]                   zeroResistorCode,
  output logic      [2:0]                   pole1CapacitorCode
);
  import scfg_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [3:0]         command_r;
  logic [3:0]         command_nxt;
  logic               doubler_r;
  logic               doubler_nxt;
  logic [1:0]         loopMode_r;
  logic [1:0]         loopMode_nxt;
  logic               sdmPdn_r;
  logic               sdmPdn_nxt;
  logic [7:0]         cpCode_r;
  logic [7:0]         cpCode_nxt;
  logic [1:0]         pole2_r;
  logic [1:0]         pole2_nxt;
  logic [2:0]         zeroRes_r;
  logic [2:0]         zeroRes_nxt;
  logic [2:0]         pole1_r;
  logic [2:0]         pole1_nxt;
  logic               calStart_r;
  logic               calStart_nxt;
  logic [7:0]         rdData_r;
  logic [7:0]         rdData_nxt;
  logic [9:0]         cpUa_r;
  logic [9:0]         cpUa_nxt;
  logic [3:0]         loopDec_r;
  logic [3:0]         loopDec_nxt;

  logic               hitCommand;
  logic               hitSelect;
  logic               hitPump;
  logic               hitFilter;

  localparam logic [DATA_W-CTRL_USED_BITS-1:0] RSVD_ZERO = '0;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // True when a write strobe targets one register
  function automatic logic writeHits(
    input logic              strobe,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] target
  );
    return strobe && (addr == target);
  endfunction

  // One-hot loop path decode: {reserved, fixed, cascaded, single}
  function automatic logic [3:0] decodeLoop(input logic [1:0] code);
    logic [3:0] res;
    res = 4'h0;
    case (scfg_loop_mode_type'(code))
      LOOP_SINGLE:   res = 4'h1;
      LOOP_CASCADED: res = 4'h2;
      LOOP_FIXDELAY: res = 4'h4;
      default:       res = 4'h8;
    endcase
    return res;
  endfunction

  // Pump current in microamps for one code
  function automatic logic [9:0] pumpMicroAmps(input logic [7:0] code);
    return 10'(code) * 10'(CP_UA_PER_LSB);
  endfunction

  // ****************************************************************
  // Write decode
  // ****************************************************************
  always_comb begin
    hitCommand = writeHits(regWrite, regAddr, CORE_COMMAND_ADDR);
    hitSelect  = writeHits(regWrite, regAddr, LOOP_SELECT_ADDR);
    hitPump    = writeHits(regWrite, regAddr, CP_CURRENT_ADDR);
    hitFilter  = writeHits(regWrite, regAddr, LOOP_FILTER_ADDR);
  end

  // ****************************************************************
  // Core command bits
  // ****************************************************************
  // Upper bits are dropped so they always read back as zero
  always_comb begin
    command_nxt = command_r;
    if (hitCommand) begin
      command_nxt = regWrData[CTRL_USED_BITS-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      command_r <= CORE_COMMAND_RST;
    end else begin
      command_r <= command_nxt;
    end
  end

  // ****************************************************************
  // Calibration pulse
  // ****************************************************************
  // Only a 0 to 1 write of the bit starts a calibration
  always_comb begin
    calStart_nxt = 1'b0;
    if (hitCommand) begin
      calStart_nxt = command_nxt[CMD_CAL_BIT] & ~command_r[CMD_CAL_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      calStart_r <= 1'b0;
    end else begin
      calStart_r <= calStart_nxt;
    end
  end

  // ****************************************************************
  // Reference doubler select
  // ****************************************************************
  always_comb begin
    doubler_nxt = doubler_r;
    if (hitSelect) begin
      doubler_nxt = regWrData[SEL_DBL_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      doubler_r <= DOUBLER_RST;
    end else begin
      doubler_r <= doubler_nxt;
    end
  end

  // ****************************************************************
  // Loop mode field
  // ****************************************************************
  always_comb begin
    loopMode_nxt = loopMode_r;
    if (hitSelect) begin
      loopMode_nxt = regWrData[SEL_MODE_HI:SEL_MODE_LO];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      loopMode_r <= LOOP_MODE_RST;
    end else begin
      loopMode_r <= loopMode_nxt;
    end
  end

  // ****************************************************************
  // Modulator power-down
  // ****************************************************************
  always_comb begin
    sdmPdn_nxt = sdmPdn_r;
    if (hitSelect) begin
      sdmPdn_nxt = regWrData[SEL_SDMPD_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sdmPdn_r <= SDM_PDN_RST;
    end else begin
      sdmPdn_r <= sdmPdn_nxt;
    end
  end

  // ****************************************************************
  // Loop path decode
  // ****************************************************************
  // Registered so the path selects change with the mode field
  always_comb begin
    loopDec_nxt = decodeLoop(loopMode_nxt);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      loopDec_r <= decodeLoop(LOOP_MODE_RST);
    end else begin
      loopDec_r <= loopDec_nxt;
    end
  end

  // ****************************************************************
  // Charge pump code
  // ****************************************************************
  always_comb begin
    cpCode_nxt = cpCode_r;
    if (hitPump) begin
      cpCode_nxt = regWrData;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cpCode_r <= CP_CURRENT_RST;
    end else begin
      cpCode_r <= cpCode_nxt;
    end
  end

  // ****************************************************************
  // Charge pump current
  // ****************************************************************
  // Follows the next code so current and code change on one edge
  always_comb begin
    cpUa_nxt = pumpMicroAmps(cpCode_nxt);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cpUa_r <= pumpMicroAmps(CP_CURRENT_RST);
    end else begin
      cpUa_r <= cpUa_nxt;
    end
  end

  // ****************************************************************
  // Pole 2 resistor
  // ****************************************************************
  always_comb begin
    pole2_nxt = pole2_r;
    if (hitFilter) begin
      pole2_nxt = regWrData[LF_P2R_HI:LF_P2R_LO];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pole2_r <= POLE2_RES_RST;
    end else begin
      pole2_r <= pole2_nxt;
    end
  end

  // ****************************************************************
  // Zero resistor
  // ****************************************************************
  always_comb begin
    zeroRes_nxt = zeroRes_r;
    if (hitFilter) begin
      zeroRes_nxt = regWrData[LF_ZR_HI:LF_ZR_LO];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      zeroRes_r <= ZERO_RES_RST;
    end else begin
      zeroRes_r <= zeroRes_nxt;
    end
  end

  // ****************************************************************
  // Pole 1 capacitor
  // ****************************************************************
  always_comb begin
    pole1_nxt = pole1_r;
    if (hitFilter) begin
      pole1_nxt = regWrData[LF_P1C_HI:LF_P1C_LO];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pole1_r <= POLE1_CAP_RST;
    end else begin
      pole1_r <= pole1_nxt;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Data stands one cycle after the strobe, zero otherwise
  always_comb begin
    rdData_nxt = 8'h00;
    if (regRead) begin
      case (regAddr)
        CORE_COMMAND_ADDR: rdData_nxt = {RSVD_ZERO, command_r};
        LOOP_SELECT_ADDR:  rdData_nxt = {RSVD_ZERO, doubler_r, loopMode_r, sdmPdn_r};
        CP_CURRENT_ADDR:   rdData_nxt = cpCode_r;
        LOOP_FILTER_ADDR:  rdData_nxt = {pole2_r, zeroRes_r, pole1_r};
        default:           rdData_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdData_r <= 8'h00;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  // ****************************************************************
  // Read data and core controls
  // ****************************************************************
  assign regRdData           = rdData_r;
  assign vcoCalStart         = calStart_r;
  assign dividerSyncHold     = command_r[CMD_SYNC_BIT];
  assign corePowerDown       = command_r[CMD_PDN_BIT];
  assign coreReset           = command_r[CMD_RST_BIT];
  assign doublerSelect       = doubler_r;
  assign loopSingle          = loopDec_r[0];
  assign loopCascaded        = loopDec_r[1];
  assign loopFixedDelay      = loopDec_r[2];
  assign loopReserved        = loopDec_r[3];
  assign sdmPowerDown        = sdmPdn_r;
  assign chargePumpCode      = cpCode_r;
  assign chargePumpMicroAmps = cpUa_r;
  assign pole2ResistorCode   = pole2_r;
  assign zeroResistorCode    = zeroRes_r;
  assign pole1CapacitorCode  = pole1_r;

endmodule

// [scfg_synth_core_config_regs_assertions.sv]
`timescale 1ns/1ps
module scfg_synth_core_config_regs_assertions (
  input wire logic                        clock,
  input wire logic                        resetn,
  input wire logic [scfg_pkg::ADDR_W-1:0] regAddr,
  input wire logic [scfg_pkg::DATA_W-1:0] regWrData,
  input wire logic                        regWrite,
  input wire logic                        regRead,
  input wire logic [scfg_pkg::DATA_W-1:0] regRdData,
  input wire logic                        vcoCalStart,
  input wire logic                        dividerSyncHold,
  input wire logic                        sdmPowerDown,
  input wire logic                        loopSingle,
  input wire logic                        loopReserved,
  input wire logic [scfg_pkg::DATA_W-1:0] chargePumpCode,
  input wire logic [9:0]                  chargePumpMicroAmps,
  input wire logic [1:0]                  pole2ResistorCode
);
  import scfg_pkg::*;
  // ********************
  // Write decode
  // ********************
  wire w0 = regWrite && regAddr == CORE_COMMAND_ADDR;
  wire w1 = regWrite && regAddr == LOOP_SELECT_ADDR;
  wire w2 = regWrite && regAddr == CP_CURRENT_ADDR;
  wire w3 = regWrite && regAddr == LOOP_FILTER_ADDR;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_cal_pulse; vcoCalStart |=> !vcoCalStart; endproperty
  a_cal_pulse: assert property (p_cal_pulse) else $error("cal pulse too long");
  property p_cal_low; w0 && !regWrData[3] |=> !vcoCalStart; endproperty
  a_cal_low: assert property (p_cal_low) else $error("cal pulse without edge");
  property p_sync; w0 |=> dividerSyncHold == $past(regWrData[2]); endproperty
  a_sync: assert property (p_sync) else $error("sync level wrong");
  property p_sdm; w1 |=> sdmPowerDown == $past(regWrData[0]); endproperty
  a_sdm: assert property (p_sdm) else $error("modulator power wrong");
  property p_mode; w1 && regWrData[2:1] == 2'h3 |=> loopReserved && !loopSingle; endproperty
  a_mode: assert property (p_mode) else $error("loop decode wrong");
  property p_cp; w2 |=> chargePumpCode == $past(regWrData); endproperty
  a_cp: assert property (p_cp) else $error("pump code wrong");
  property p_ua; chargePumpMicroAmps == {chargePumpCode, 2'h0}; endproperty
  a_ua: assert property (p_ua) else $error("pump current wrong");
  property p_p2r; w3 |=> pole2ResistorCode == $past(regWrData[7:6]); endproperty
  a_p2r: assert property (p_p2r) else $error("pole2 code wrong");
  property p_rsvd; regRead && regAddr == CORE_COMMAND_ADDR |=> regRdData[7:4] == 4'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
endmodule
bind scfg_synth_core_config_regs scfg_synth_core_config_regs_assertions chk_u (.clock, .resetn,
  .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .vcoCalStart, .dividerSyncHold,
  .sdmPowerDown, .loopSingle, .loopReserved, .chargePumpCode, .chargePumpMicroAmps,
  .pole2ResistorCode);

// [test_synth_core_config_regs.sv]
`timescale 1ns/1ps
module test_synth_core_config_regs;
  import scfg_pkg::*;
  logic clock = 1'h0, resetn = 1'h0, regWrite = 1'h0, regRead = 1'h0;
  logic [ADDR_W-1:0] regAddr = 10'h000;
  logic [DATA_W-1:0] regWrData = 8'h00, regRdData, chargePumpCode;
  logic vcoCalStart, dividerSyncHold, corePowerDown, coreReset, doublerSelect, sdmPowerDown;
  logic loopSingle, loopCascaded, loopFixedDelay, loopReserved;
  logic [9:0] chargePumpMicroAmps;
  logic [1:0] pole2ResistorCode;
  logic [2:0] zeroResistorCode, pole1CapacitorCode;
  int miscompares = 0, samples_checked = 0;
  scfg_synth_core_config_regs dut_u (.clock, .resetn, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .vcoCalStart, .dividerSyncHold, .corePowerDown, .coreReset,
    .doublerSelect, .loopSingle, .loopCascaded, .loopFixedDelay, .loopReserved, .sdmPowerDown,
    .chargePumpCode, .chargePumpMicroAmps, .pole2ResistorCode, .zeroResistorCode,
    .pole1CapacitorCode);
  // ********************
  // Bus tasks
  // ********************
  task automatic chk(string n, logic [9:0] seen, logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(logic [9:0] a, logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 1'h0;
    #1;
  endtask
  task automatic rd(logic [9:0] a, logic [7:0] exp);
    @(posedge clock);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'h0;
    #1;
    chk("read", regRdData, exp);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ********************
  // Stimulus
  // ********************
  initial forever #2.5 clock = ~clock;
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'h1;
    #1;
    chk("ua", chargePumpMicroAmps, 10'h234);
    chk("mode", {loopReserved, loopFixedDelay, loopCascaded, loopSingle}, 10'h001);
    rd(CORE_COMMAND_ADDR, 8'h00);
    rd(LOOP_SELECT_ADDR, 8'h01);
    rd(CP_CURRENT_ADDR, 8'h8d);
    rd(LOOP_FILTER_ADDR, 8'he8);
    wr(CORE_COMMAND_ADDR, 8'hff);
    chk("cal", vcoCalStart, 10'h001);
    chk("cmd", {dividerSyncHold, corePowerDown, coreReset}, 10'h007);
    @(posedge clock);
    #1;
    chk("cal", vcoCalStart, 10'h000);
    wr(CORE_COMMAND_ADDR, 8'h0f);
    chk("cal", vcoCalStart, 10'h000);
    rd(CORE_COMMAND_ADDR, 8'h0f);
    wr(CORE_COMMAND_ADDR, 8'h00);
    chk("cmd", {dividerSyncHold, corePowerDown, coreReset}, 10'h000);
    wr(CORE_COMMAND_ADDR, 8'h08);
    chk("cal", vcoCalStart, 10'h001);
    for (int m = 0; m < 4; m++) begin
      wr(LOOP_SELECT_ADDR, {4'hf, m[0], m[1:0], m[0]});
      chk("mode", {loopReserved, loopFixedDelay, loopCascaded, loopSingle}, 10'(1 << m));
      chk("dbl", {doublerSelect, sdmPowerDown}, {m[0], m[0]});
      rd(LOOP_SELECT_ADDR, {4'h0, m[0], m[1:0], m[0]});
    end
    wr(CP_CURRENT_ADDR, 8'hff);
    chk("ua", chargePumpMicroAmps, 10'h3fc);
    wr(LOOP_FILTER_ADDR, 8'h1d);
    chk("lf", {pole2ResistorCode, zeroResistorCode, pole1CapacitorCode}, 10'h01d);
    wr(10'h104, 8'h55);
    rd(10'h104, 8'h00);
    rd(CP_CURRENT_ADDR, 8'hff);
    @(posedge clock);
    resetn <= 1'h0;
    @(posedge clock);
    resetn <= 1'h1;
    #1;
    chk("ua", chargePumpMicroAmps, 10'h234);
    rd(CP_CURRENT_ADDR, 8'h8d);
    conclude();
  end
endmodule
